// >>> inc/flash_erase_pkg.sv
package flash_erase_pkg;
  // Opcodes
  localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
  localparam logic [7:0] OP_ARRAY_ERASE0 = 8'hC7;
  localparam logic [7:0] OP_ARRAY_ERASE1 = 8'h94;
  localparam logic [7:0] OP_ARRAY_ERASE2 = 8'h80;
  localparam logic [7:0] OP_ARRAY_ERASE3 = 8'h9A;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;
  // Frame lengths in bits
  localparam int CMD_BITS   = 32;
  localparam int BIT_CNT_W  = 6;
  localparam logic [5:0] FRAME_BITS = 6'h20;
  // Address field positions within the 24-bit address
  localparam int STD_PAGE_LSB = 10;  // Page bit 0 in standard mode
  localparam int BIN_PAGE_LSB = 9;   // Page bit 0 in binary mode
  localparam int BLK_SHIFT    = 3;   // Page bits 11..3 select a block
  localparam int SEC_SHIFT    = 8;   // Page bits 11..8 select a sector
  localparam int SEC_COUNT    = 17;  // 0a, 0b, 1..15
  localparam int BLOCK_COUNT  = 512;
  // Erase times in microseconds
  localparam int BLOCK_ERASE_TIME_US  = 45000;
  localparam int SECTOR_ERASE_TIME_US = 1600000;
  localparam int ARRAY_ERASE_TIME_US  = 12000000;
  localparam int CLK_MHZ = 250;
  localparam longint BLOCK_ERASE_CYC  = longint'(BLOCK_ERASE_TIME_US) * CLK_MHZ;
  localparam longint SECTOR_ERASE_CYC = longint'(SECTOR_ERASE_TIME_US) * CLK_MHZ;
  localparam longint ARRAY_ERASE_CYC  = longint'(ARRAY_ERASE_TIME_US) * CLK_MHZ;
  // Kind of erase
  typedef enum logic [1:0] {ER_NONE, ER_BLOCK, ER_SECTOR, ER_ARRAY} erase_kind_t;
endpackage

// >>> inc/flash_link_if.sv
`timescale 1ns/1ps
interface flash_link_if;
  logic sck;       // Serial clock from host
  logic cs_n;      // Chip select, active low
  logic si;        // Host to device data
  logic so;        // Device to host data
  logic rdy_busy_n;// High when ready, low when busy
  modport device (input sck, input cs_n, input si, output so,
                  output rdy_busy_n);
  modport host (output sck, output cs_n, output si, input so,
                input rdy_busy_n);
endinterface

// >>> rtl/flash_erase_dev.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Block erase clears eight consecutive pages
// [R2] Standard block address: page bits 11..3
// [R3] Binary block address: bits 20..12
// [R4] Nine bits index block, low page bits ignored
// [R5] Block erase starts on chip select rise
// [R6] Busy in status and ready pin
// [R7] Sector erase erases exactly one sector
// [R8] Standard sector 0a/0b by page bits 11..3
// [R9] Binary sector 0a/0b by bits 20..12
// [R10] Sectors 1-15 from top four page bits
// [R11] Any page inside sector selects it
// [R12] Sector erase starts on chip select rise
// [R13] Array erase is fixed four-byte opcode
// [R14] Bytes after array opcode are discarded
// [R15] Chip select release launches array erase
// [R16] Status busy until array erase ends
// [R17] Array erase skips protected or locked sectors
// [R18] Write-protect takes effect after running erase
// [R19] Erased locations read as all ones
// [R20] Short frames start no erase
module flash_erase_dev
  import flash_erase_pkg::*;
#(
  parameter longint BLOCK_CYC  = BLOCK_ERASE_CYC,
  parameter longint SECTOR_CYC = SECTOR_ERASE_CYC,
  parameter longint ARRAY_CYC  = ARRAY_ERASE_CYC
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Link
  flash_link_if.device               link,
  // Configuration and protection
  input  wire logic                  i_binary_page,   // 512-byte mode
  input  wire logic                  i_wp_n,          // Write protect
  input  wire logic [SEC_COUNT-1:0]  i_sec_protect,   // Protect map
  input  wire logic [SEC_COUNT-1:0]  i_sec_lock,      // Lockdown map
  input  wire logic                  i_prot_cmd_en,   // Software enable
  // User side status
  output logic                       o_busy,          // Status busy bit
  output logic                       o_erase_start,   // Pulse at start
  output logic                       o_erase_done,    // Pulse at end
  output erase_kind_t                o_erase_kind,    // Running erase
  output logic [8:0]                 o_block_index,   // Selected block
  output logic [SEC_COUNT-1:0]       o_sector_mask,   // Sectors erased
  output logic [7:0]                 o_erase_fill     // Erased value
);
  import flash_erase_pkg::*;

  // Idle takes frames; erase runs on its own timer with no serial clock
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE} state_t;

  // All state of the device
  typedef struct packed {
    logic [1:0]            sck_s;    // Sync chain for clock
    logic [1:0]            cs_s;     // Sync chain for select
    logic [1:0]            si_s;     // Sync chain for data
    logic [1:0]            wp_s;     // Sync chain for protect
    logic                  sck_d;    // Previous synced clock
    logic                  cs_d;     // Previous synced select
    logic [BIT_CNT_W-1:0]  nbits;    // Bits taken this frame
    logic [CMD_BITS-1:0]   shreg;    // First 32 bits of frame
    state_t                state;
    erase_kind_t           kind;
    // Wide enough that the longest erase load never wraps
    logic [63:0]           timer;    // Erase time left
    logic                  prot;     // Active protection
    logic                  busy;
    logic                  start;
    logic                  done;
    logic [8:0]            blk;
    logic [SEC_COUNT-1:0]  smask;
  } dev_t;

  dev_t st_reg, st_next;

  logic [11:0] page;      // Page address from frame
  logic [8:0]  sel9;      // Nine select bits
  logic [3:0]  sel4;      // Four sector bits
  logic        frame_end; // Select rising edge
  logic        full;      // Whole frame received

  // Decode the captured frame
  // Standard mode has two spare bits above the page, binary mode three,
  // so the page field sits one place lower in binary mode
  always_comb begin
    page = i_binary_page ? st_reg.shreg[BIN_PAGE_LSB +: 12]
                         : st_reg.shreg[STD_PAGE_LSB +: 12]; // R2 R3
    sel9 = page[11:BLK_SHIFT];  // R4
    sel4 = page[11:SEC_SHIFT];  // R10 R11
    frame_end = st_reg.cs_s[1] && !st_reg.cs_d;
    // A frame shorter than opcode plus address leaves this low
    full = (st_reg.nbits >= FRAME_BITS);  // R20
  end

  // Next state
  // Every pin passes two flops; edge detectors only look at the second
  always_comb begin
    st_next = st_reg;
    // Pin synchronisers
    st_next.sck_s = {st_reg.sck_s[0], link.sck};
    st_next.cs_s  = {st_reg.cs_s[0], link.cs_n};
    st_next.si_s  = {st_reg.si_s[0], link.si};
    st_next.wp_s  = {st_reg.wp_s[0], i_wp_n};
    st_next.sck_d = st_reg.sck_s[1];
    st_next.cs_d  = st_reg.cs_s[1];
    // Pulses last a single cycle unless set below
    st_next.start = 1'b0;
    st_next.done  = 1'b0;
    // Protect follows pin only between erases
    if (st_reg.state == ST_IDLE) begin
      st_next.prot = i_prot_cmd_en || !st_reg.wp_s[1];  // R18
    end
    // Shift bits on rising serial clock while selected (mode 0 and 3)
    if (!st_reg.cs_s[1] && st_reg.sck_s[1] && !st_reg.sck_d) begin
      if (st_reg.nbits < FRAME_BITS) begin
        st_next.shreg = {st_reg.shreg[CMD_BITS-2:0], st_reg.si_s[1]};
        st_next.nbits = st_reg.nbits + 1'b1;
      end
      // Later bits are dropped
      // R14
    end
    case (st_reg.state)
      ST_IDLE: begin
        // Commands are ignored while busy; only decode when idle
        if (frame_end && full) begin  // R5 R12 R15 R20
          if (st_reg.shreg[31:24] == OP_BLOCK_ERASE) begin  // R1
            st_next.kind  = ER_BLOCK;
            st_next.blk   = sel9;
            st_next.smask = '0;
            st_next.timer = BLOCK_CYC;
            st_next.state = ST_ERASE;
          end else if (st_reg.shreg[31:24] == OP_SECTOR_ERASE) begin
            st_next.kind  = ER_SECTOR;  // R7
            st_next.smask = '0;
            // Sector N lives in mask bit N+1, after 0a and 0b
            if (sel4 != 4'h0) begin
              st_next.smask[sel4 + 5'h01] = 1'b1;  // R10
            end else if (sel9[0]) begin
              st_next.smask[1] = 1'b1;  // R8 R9: sector 0b
            end else begin
              st_next.smask[0] = 1'b1;  // Sector 0a
            end
            st_next.timer = SECTOR_CYC;
            st_next.state = ST_ERASE;
          end else if (st_reg.shreg == {OP_ARRAY_ERASE0, OP_ARRAY_ERASE1,
                                        OP_ARRAY_ERASE2, OP_ARRAY_ERASE3})
          begin  // R13
            st_next.kind  = ER_ARRAY;
            // Protected sectors count only while protection is on;
            // locked sectors are never erased
            st_next.smask = ~(st_reg.prot ? i_sec_protect : '0) &
                            ~i_sec_lock;  // R17
            st_next.timer = ARRAY_CYC;
            st_next.state = ST_ERASE;
          end
          if (st_next.state == ST_ERASE) begin
            st_next.busy  = 1'b1;  // R6 R16
            st_next.start = 1'b1;
          end
        end
      end
      ST_ERASE: begin
        // Self-timed, no serial clock needed
        // Busy lasts exactly the timer load in cycles
        // Frames that arrive now are dropped whole; the host must wait
        if (st_reg.timer <= 64'd1) begin
          st_next.state = ST_IDLE;
          st_next.busy  = 1'b0;
          st_next.done  = 1'b1;
          st_next.kind  = ER_NONE;
        end else begin
          st_next.timer = st_reg.timer - 64'd1;
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
    // New frame clears the bit count
    if (frame_end || st_reg.cs_s[1]) begin
      st_next.nbits = '0;
    end
  end

  // State register
  // Sync chains reset to pin idle levels so no false edge follows reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '{sck_s: 2'h0, cs_s: 2'h3, si_s: 2'h0, wp_s: 2'h3,
                  sck_d: 1'b0, cs_d: 1'b1, nbits: '0, shreg: '0,
                  state: ST_IDLE, kind: ER_NONE, timer: '0, prot: 1'b0,
                  busy: 1'b0, start: 1'b0, done: 1'b0, blk: '0,
                  smask: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops, or tied to constants
  // Erase commands return no data, so serial out is held low
  assign link.so       = 1'b0;
  // Ready pin and status bit come from one flop and cannot disagree
  assign link.rdy_busy_n = !st_reg.busy;  // R6
  assign o_busy        = st_reg.busy;
  assign o_erase_start = st_reg.start;
  assign o_erase_done  = st_reg.done;
  assign o_erase_kind  = st_reg.kind;
  assign o_block_index = st_reg.blk;
  assign o_sector_mask = st_reg.smask;
  assign o_erase_fill  = ERASED_BYTE;  // R19
endmodule

// >>> rtl/flash_erase_host.sv
`timescale 1ns/1ps
module flash_erase_host
  import flash_erase_pkg::*;
#(
  parameter int SCK_HALF = 10  // System cycles per half serial clock
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Link
  flash_link_if.host                link,
  // Command request
  input  wire logic                 i_req,      // Start pulse
  input  wire erase_kind_t          i_kind,     // Erase kind
  input  wire logic [23:0]          i_addr,     // Address bytes
  // Status
  output logic                      o_ready,    // Idle and not busy
  output logic                      o_dev_busy  // Device busy
);
  import flash_erase_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} hstate_t;

  typedef struct packed {
    logic [1:0]          rb_s;   // Ready pin sync
    hstate_t             state;
    logic [31:0]         sh;     // Frame to send
    logic [BIT_CNT_W-1:0] nbits;
    logic [15:0]         div;
    logic                sck;
    logic                cs_n;
    logic                si;
    logic                ready;
  } host_t;

  host_t h_reg, h_next;

  // Next state
  always_comb begin
    h_next = h_reg;
    h_next.rb_s = {h_reg.rb_s[0], link.rdy_busy_n};
    // Ready waits out a settle time after each frame, since the busy
    // answer needs several cycles to come back through the sync;
    // SCK_HALF must therefore be at least 6
    h_next.ready = (h_reg.state == H_IDLE) && h_reg.rb_s[1] &&
                   (h_reg.div == 16'(SCK_HALF - 1));
    case (h_reg.state)
      H_IDLE: begin
        // Settle counter stops at its end value
        if (h_reg.div != 16'(SCK_HALF - 1)) begin
          h_next.div = h_reg.div + 16'h0001;
        end
        if (i_req && h_reg.ready && i_kind != ER_NONE) begin
          // Opcode then address; array erase uses fixed sequence (R13)
          case (i_kind)
            ER_BLOCK:  h_next.sh = {OP_BLOCK_ERASE, i_addr};   // R2 R3
            ER_SECTOR: h_next.sh = {OP_SECTOR_ERASE, i_addr};  // R8 R9 R10
            default:   h_next.sh = {OP_ARRAY_ERASE0, OP_ARRAY_ERASE1,
                                    OP_ARRAY_ERASE2, OP_ARRAY_ERASE3};
          endcase
          h_next.cs_n  = 1'b0;
          h_next.si    = h_next.sh[31];
          h_next.nbits = '0;
          h_next.div   = '0;
          h_next.ready = 1'b0;
          h_next.state = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (h_reg.div == 16'(SCK_HALF - 1)) begin
          h_next.div = '0;
          h_next.sck = !h_reg.sck;
          if (h_reg.sck) begin
            // Falling edge: present next bit
            h_next.sh    = {h_reg.sh[30:0], 1'b0};
            h_next.si    = h_reg.sh[30];
            h_next.nbits = h_reg.nbits + 1'b1;
            if (h_reg.nbits == FRAME_BITS - 1'b1) begin
              h_next.state = H_GAP;
            end
          end
        end else begin
          h_next.div = h_reg.div + 16'h0001;
        end
      end
      H_GAP: begin
        // Release select after last bit to launch erase
        if (h_reg.div == 16'(SCK_HALF - 1)) begin
          h_next.cs_n  = 1'b1;  // R15
          h_next.div   = '0;
          h_next.state = H_IDLE;
        end else begin
          h_next.div = h_reg.div + 16'h0001;
        end
      end
      default: h_next.state = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      h_reg <= '{rb_s: 2'h3, state: H_IDLE, sh: '0, nbits: '0, div: '0,
                 sck: 1'b0, cs_n: 1'b1, si: 1'b0, ready: 1'b0};
    end else begin
      h_reg <= h_next;
    end
  end

  assign link.sck  = h_reg.sck;
  assign link.cs_n = h_reg.cs_n;
  assign link.si   = h_reg.si;
  assign o_ready    = h_reg.ready;
  assign o_dev_busy = !h_reg.rb_s[1];
endmodule

// >>> test/flash_erase_checker.sv
`timescale 1ns/1ps
module flash_erase_checker #(
  parameter longint BLOCK_CYC  = 40,
  parameter longint SECTOR_CYC = 60,
  parameter longint ARRAY_CYC  = 80
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Link wires
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic so,
  input  wire logic rdy_busy_n
);
  logic [5:0] nbits_reg;  // Serial clock rises in this frame
  int         blen_reg;   // Cycles spent busy so far
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Helper counts; busy length is kept so one check covers all three kinds
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      nbits_reg <= 6'h00;
      blen_reg  <= 0;
    end else begin
      if (cs_n) nbits_reg <= 6'h00;
      else if ($rose(sck)) nbits_reg <= nbits_reg + 6'h01;
      blen_reg <= rdy_busy_n ? 0 : blen_reg + 1;
    end
  end
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("serial clock not low outside frame");
  AST_SI_STABLE: assert property ($rose(sck) |-> $stable(si))
    else $error("data moved at serial clock rise");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> nbits_reg == 6'h20)
    else $error("frame not 32 bits");
  AST_BUSY_START: assert property ($rose(cs_n) |-> ##[1:8] !rdy_busy_n)
    else $error("no busy after frame end");
  AST_BUSY_LEN: assert property ($rose(rdy_busy_n) |-> blen_reg inside
    {[BLOCK_CYC-1:BLOCK_CYC+1], [SECTOR_CYC-1:SECTOR_CYC+1],
     [ARRAY_CYC-1:ARRAY_CYC+1]})
    else $error("busy length wrong");
  AST_NO_FRAME_BUSY: assert property (!rdy_busy_n |-> cs_n)
    else $error("frame sent while busy");
  AST_CS_FALL: assert property ($fell(cs_n) |-> !sck && rdy_busy_n)
    else $error("frame opened badly");
  AST_QUIET_IN_FRAME: assert property (rdy_busy_n && !cs_n |=> rdy_busy_n)
    else $error("busy rose inside frame");
  // Main scenarios
  cover property ($rose(cs_n));
  cover property ($fell(rdy_busy_n));
  cover property ($rose(rdy_busy_n));
endmodule

// >>> test/serial_flash_erase_commands_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
  $display("BAD %s exp %h got %h", n, e, s); err_total++; end end
module serial_flash_erase_commands_tb_top;
  import flash_erase_pkg::*;
  logic        i_clk = 1'b0;       // System clock
  logic        i_rst = 1'b1;       // Reset
  logic        host_req = 1'b0;    // Host user side
  erase_kind_t host_kind = ER_BLOCK;
  logic [23:0] host_addr = 24'h000000;
  logic        bin_page = 1'b0;    // Shared device config
  logic        wp_n = 1'b1;
  logic        prot_en = 1'b0;
  logic [16:0] sec_prot = 17'h00000;
  logic [16:0] sec_lock = 17'h00000;
  logic        ready, busy_a, start_a, done_a, busy_b, start_b;
  logic        dev_busy;           // Host view of the ready pin
  localparam longint T_BLOCK   = 40;    // Short erase times for the run
  localparam longint T_SECTOR  = 60;
  localparam longint T_ARRAY   = 80;
  localparam longint T_ARRAY_B = 4000;  // Long enough to land a frame
  erase_kind_t kind_a;
  logic [8:0]  blk_a;
  logic [16:0] mask_a, exp_m;
  logic [7:0]  fill_a;
  logic [11:0] pg;
  logic [31:0] r;
  int          seed = 32'hb0fcbb26;
  int          err_total = 0;
  int          samples_checked = 0;
  int          starts_b = 0;     // Starts seen on the rule-breaking link
  flash_link_if link_a();
  flash_link_if link_b();
  always #2 i_clk = ~i_clk;
  // Host keeps its default divider, an 80 ns serial clock
  flash_erase_host u_flash_erase_host (.i_clk(i_clk),
    .i_rst(i_rst), .link(link_a), .i_req(host_req), .i_kind(host_kind),
    .i_addr(host_addr), .o_ready(ready), .o_dev_busy(dev_busy));
  flash_erase_dev #(.BLOCK_CYC(T_BLOCK), .SECTOR_CYC(T_SECTOR),
    .ARRAY_CYC(T_ARRAY))
    u_flash_erase_dev (.i_clk(i_clk), .i_rst(i_rst), .link(link_a),
    .i_binary_page(bin_page), .i_wp_n(wp_n), .i_sec_protect(sec_prot),
    .i_sec_lock(sec_lock), .i_prot_cmd_en(prot_en), .o_busy(busy_a),
    .o_erase_start(start_a), .o_erase_done(done_a), .o_erase_kind(kind_a),
    .o_block_index(blk_a), .o_sector_mask(mask_a), .o_erase_fill(fill_a));
  // Long array erase here so a frame can land while busy
  // Only the array time matters here; the last block erase is not awaited
  flash_erase_dev #(.ARRAY_CYC(T_ARRAY_B))
    u_flash_erase_dev_b (.i_clk(i_clk), .i_rst(i_rst), .link(link_b),
    .i_binary_page(bin_page), .i_wp_n(wp_n), .i_sec_protect(sec_prot),
    .i_sec_lock(sec_lock), .i_prot_cmd_en(prot_en), .o_busy(busy_b),
    .o_erase_start(start_b), .o_erase_done(), .o_erase_kind(),
    .o_block_index(), .o_sector_mask(), .o_erase_fill());
  // Checker defaults equal the short erase times above
  flash_erase_checker
    u_flash_erase_checker (.i_clk(i_clk), .i_rst(i_rst), .sck(link_a.sck),
    .cs_n(link_a.cs_n), .si(link_a.si), .so(link_a.so),
    .rdy_busy_n(link_a.rdy_busy_n));
  // Count starts on the second link
  always @(posedge i_clk) if (start_b === 1'b1) starts_b++;
  // Print the verdict and stop
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Waits on negedge until a flag is high, bounded
  task automatic wait_hi(ref logic f, input int lim);
    for (int n = 0; n < lim && f !== 1'b1; n++) @(negedge i_clk);
  endtask
  // One erase through the host; page field placed per page-size mode
  task automatic run_op(input erase_kind_t k, input logic [16:0] em,
                        input logic wp_mid);
    host_addr = 24'($random(seed));
    if (bin_page) host_addr[BIN_PAGE_LSB +: 12] = pg;
    else host_addr[STD_PAGE_LSB +: 12] = pg;
    wait_hi(ready, 3000);
    host_kind = k;
    host_req = 1'b1;
    @(negedge i_clk);
    host_req = 1'b0;
    wait_hi(start_a, 3000);
    `CHK("start", 1'b1, start_a)
    `CHK("kind", k, kind_a)
    `CHK("fill", ERASED_BYTE, fill_a)
    if (k == ER_BLOCK) `CHK("block", pg[11:3], blk_a)
    else `CHK("mask", em, mask_a)
    @(negedge i_clk);
    `CHK("busy", 2'b11, {busy_a, ~link_a.rdy_busy_n})
    repeat (2) @(negedge i_clk);
    `CHK("host_busy", 2'b10, {dev_busy, ready})
    if (wp_mid) wp_n = 1'b0;
    wait_hi(done_a, 3000);
    `CHK("done", 1'b1, done_a)
    if (k == ER_ARRAY) `CHK("mask_end", em, mask_a)
  endtask
  // Raw frame on the second link; the data line flips once released
  task automatic raw_frame(input logic [39:0] b, input int nb);
    link_b.cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      link_b.si = b[39-i];
      #40 link_b.sck = 1'b1;
      #40 link_b.sck = 1'b0;
    end
    #40 link_b.cs_n = 1'b1;
    link_b.si = ~link_b.si;
    #200;
  endtask
  initial begin
    link_b.sck = 1'b0;
    link_b.cs_n = 1'b1;
    link_b.si = 1'b0;
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    // Block erase, both modes, first and last block
    for (int i = 0; i < 8; i++) begin
      bin_page = i[0];
      pg = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($random(seed));
      run_op(ER_BLOCK, 17'h00000, 1'b0);
    end
    // Every sector, random mode and random page inside it
    for (int s = 0; s < 17; s++) begin
      bin_page = 1'($random(seed));
      r = $random(seed);
      pg = (s < 2) ? {8'h00, s[0], r[2:0]} : {4'(s - 1), r[7:0]};
      run_op(ER_SECTOR, 17'h00001 << s, 1'b0);
    end
    // Array erase with protection maps; write-protect raised mid-erase
    for (int j = 0; j < 4; j++) begin
      sec_prot = 17'($random(seed));
      sec_lock = 17'($random(seed));
      prot_en = (j == 1);
      if (j < 3) wp_n = 1'b1;
      exp_m = ~(sec_lock | ((prot_en | ~wp_n) ? sec_prot : 17'h00000));
      run_op(ER_ARRAY, exp_m, j == 2);
    end
    wp_n = 1'b1;
    bin_page = 1'b0;
    @(negedge i_clk);
    raw_frame(40'hC794809AA5, 40);
    `CHK("b_start", 1, starts_b)
    `CHK("b_busy", 1'b1, busy_b)
    raw_frame(40'h5000000000, 32);
    for (int n = 0; n < 6000 && busy_b !== 1'b0; n++) @(negedge i_clk);
    `CHK("b_idle", 1'b0, busy_b)
    `CHK("b_refuse", 1, starts_b)
    raw_frame(40'h5000000000, 31);
    `CHK("b_short", 1, starts_b)
    raw_frame(40'h3D00000000, 32);
    `CHK("b_badop", 1, starts_b)
    raw_frame(40'h5000100000, 32);
    `CHK("b_block", 2, starts_b)
    tally_and_finish();
  end
  // Watchdog well past the expected run length
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end
endmodule
